/* inc/fzf_defs.vh */
// constants for the fan zone filter, table floor and pull-down register bank
`ifndef FZF_DEFS_VH
`define FZF_DEFS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FZF_ADDR_SPIKE_CTRL 8'hC2
`define FZF_ADDR_LUT12 8'hC3
`define FZF_ADDR_LUT34 8'hC4
`define FZF_ADDR_PULLDOWN 8'hC5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FZF_RST_SPIKE_CTRL 8'h00
`define FZF_RST_LUT12 8'h00
`define FZF_RST_LUT34 8'h00
`define FZF_RST_PULLDOWN 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FZF_WIN_A_HI 2
`define FZF_WIN_A_LO 0
`define FZF_USE_A_BIT 3
`define FZF_WIN_B_HI 6
`define FZF_WIN_B_LO 4
`define FZF_USE_B_BIT 7
`define FZF_HYST_HI 3
`define FZF_HYST_LO 0
`define FZF_FLOOR_HI 7
`define FZF_FLOOR_LO 4

// ----------------------------------------------------------------
// floor duty steps and filter shifts per window code
// ----------------------------------------------------------------
`define FZF_FLOOR_TOP_STEP 4'hC
// code 0 sits in the low three bits: shifts 6,5,5,4,4,3,2,2 for codes 0..7
`define FZF_SHIFT_TABLE 24'b010_010_011_100_100_101_101_110
`define FZF_FRAC_BITS 4

`endif

/* src/fzf_regs.v */
// fan zone filter, table floor / hysteresis and pin pull-down register bank
// ----------------------------------------------------------------
// Functional notes
// - low window code sets zone a filter
// - bits six-four set zone b filter window
// - bit three selects filtered temperature, zone a
// - bit seven selects filtered temperature, zone b
// - filter always runs, result stays readable
// - raw reading stays unfiltered at all times
// - low nibble is table pair a hysteresis
// - low nibble is table pair b hysteresis
// - special-function bit four sets pair a unit
// - special-function bit five sets pair b unit
// - high nibble is pair a floor duty
// - high nibble is pair b floor duty
// - set bit pulls its pin low
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "fzf_defs.vh"

module fzf_regs (
    // clock and reset
    input wire CORE_CLK,
    input wire RST,
    // register port from the management interface
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire [7:0] REG_WDATA,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    // temperature readings, zones 1a 2a 1b 2b in byte order
    input wire [31:0] RAW_TEMP,
    input wire CONV_DONE,
    // special-function unit selects
    input wire HYST_UNIT_A_SEL,
    input wire HYST_UNIT_B_SEL,
    // filtered results, 12 bits per zone, 1/16 degree
    output reg [47:0] FILT_TEMP,
    // temperatures used by limit checks and fan control
    output reg [31:0] CTRL_TEMP,
    // table pair controls
    output reg [4:0] TABLE_PAIR_A_HYST_HALF,
    output reg [4:0] TABLE_PAIR_B_HYST_HALF,
    output reg [3:0] TABLE_PAIR_A_FLOOR_STEP,
    output reg [3:0] TABLE_PAIR_B_FLOOR_STEP,
    // general-purpose pins, open drain
    output reg [7:0] PIN_PULL_OUT,
    output reg [7:0] PIN_PULL_OE
);

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    reg [7:0] spike_ctrl_reg;
    reg [7:0] lut12_reg;
    reg [7:0] lut34_reg;
    reg [7:0] pulldown_reg;
    reg [7:0] rdata_next;

    wire [2:0] zone_a_filter_window;
    wire [2:0] zone_b_filter_window;
    wire zone_a_use_filtered;
    wire zone_b_use_filtered;
    wire [3:0] table_pair_a_hysteresis;
    wire [3:0] table_pair_b_hysteresis;
    wire [3:0] table_pair_a_floor_duty;
    wire [3:0] table_pair_b_floor_duty;

    // field views of the stored registers
    assign zone_a_filter_window = spike_ctrl_reg[`FZF_WIN_A_HI:`FZF_WIN_A_LO];
    assign zone_b_filter_window = spike_ctrl_reg[`FZF_WIN_B_HI:`FZF_WIN_B_LO];
    assign zone_a_use_filtered = spike_ctrl_reg[`FZF_USE_A_BIT];
    assign zone_b_use_filtered = spike_ctrl_reg[`FZF_USE_B_BIT];
    assign table_pair_a_hysteresis = lut12_reg[`FZF_HYST_HI:`FZF_HYST_LO];
    assign table_pair_b_hysteresis = lut34_reg[`FZF_HYST_HI:`FZF_HYST_LO];
    assign table_pair_a_floor_duty = lut12_reg[`FZF_FLOOR_HI:`FZF_FLOOR_LO];
    assign table_pair_b_floor_duty = lut34_reg[`FZF_FLOOR_HI:`FZF_FLOOR_LO];

    // register writes, all four registers fully writable
    always @(posedge CORE_CLK) begin
        if (RST) begin
            spike_ctrl_reg <= `FZF_RST_SPIKE_CTRL;
            lut12_reg <= `FZF_RST_LUT12;
            lut34_reg <= `FZF_RST_LUT34;
            pulldown_reg <= `FZF_RST_PULLDOWN;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `FZF_ADDR_SPIKE_CTRL: begin
                    spike_ctrl_reg <= REG_WDATA;
                end
                `FZF_ADDR_LUT12: begin
                    lut12_reg <= REG_WDATA;
                end
                `FZF_ADDR_LUT34: begin
                    lut34_reg <= REG_WDATA;
                end
                `FZF_ADDR_PULLDOWN: begin
                    pulldown_reg <= REG_WDATA;
                end
                // unmapped offsets leave every register unchanged
                default: begin
                    spike_ctrl_reg <= spike_ctrl_reg;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // read mux, unmapped offsets answer zero
    always @* begin
        case (REG_ADDR)
            `FZF_ADDR_SPIKE_CTRL: rdata_next = spike_ctrl_reg;
            `FZF_ADDR_LUT12: rdata_next = lut12_reg;
            `FZF_ADDR_LUT34: rdata_next = lut34_reg;
            `FZF_ADDR_PULLDOWN: rdata_next = pulldown_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    // read data registered one cycle after the strobe, held otherwise
    always @(posedge CORE_CLK) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // spike filters, one per zone
    // ----------------------------------------------------------------
    genvar zi;
    generate
        for (zi = 0; zi < 4; zi = zi + 1) begin : g_zone
            wire [2:0] win_code;
            wire use_filt;
            wire [2:0] shift;
            wire [23:0] shift_table;
            wire [7:0] raw;
            wire signed [13:0] err;
            wire signed [13:0] step;
            reg [11:0] filt_reg;
            reg [11:0] filt_next;

            // zones 0,1 follow window a, zones 2,3 follow window b
            assign win_code = (zi < 2) ? zone_a_filter_window : zone_b_filter_window;
            assign use_filt = (zi < 2) ? zone_a_use_filtered : zone_b_use_filtered;
            // shift per window code from a packed table, code 0 is the longest window
            assign shift_table = `FZF_SHIFT_TABLE;
            assign shift = shift_table[win_code*3 +: 3];
            assign raw = RAW_TEMP[zi*8 +: 8];
            // error in 1/16 degree steps
            // two guard bits keep the sign and the full 8.4 span
            assign err = $signed({2'b00, raw, 4'h0}) - $signed({2'b00, filt_reg});
            assign step = err >>> shift;

            // first-order low pass, advances once per conversion
            always @* begin
                filt_next = filt_reg;
                if (CONV_DONE) begin
                    filt_next = filt_reg + step[11:0];
                    // a step shifted to zero is forced to one lsb, else the filter stalls short
                    if (step == 14'sd0 && err != 14'sd0) begin
                        filt_next = filt_reg + (err[13] ? 12'hFFF : 12'h001);
                    end
                end
            end

            // filter runs whatever the use bit says
            always @(posedge CORE_CLK) begin
                if (RST) begin
                    filt_reg <= 12'h000;
                    FILT_TEMP[zi*12 +: 12] <= 12'h000;
                    CTRL_TEMP[zi*8 +: 8] <= 8'h00;
                end else begin
                    filt_reg <= filt_next;
                    FILT_TEMP[zi*12 +: 12] <= filt_next;
                    if (use_filt) begin
                        CTRL_TEMP[zi*8 +: 8] <= filt_reg[11:`FZF_FRAC_BITS];
                    end else begin
                        CTRL_TEMP[zi*8 +: 8] <= raw;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // table pair outputs and pin pull-downs
    // ----------------------------------------------------------------
    // hysteresis scaled to half degrees; floor codes clamped to mapped steps
    always @(posedge CORE_CLK) begin
        if (RST) begin
            TABLE_PAIR_A_HYST_HALF <= 5'h00;
            TABLE_PAIR_B_HYST_HALF <= 5'h00;
            TABLE_PAIR_A_FLOOR_STEP <= 4'h0;
            TABLE_PAIR_B_FLOOR_STEP <= 4'h0;
            PIN_PULL_OUT <= 8'h00;
            PIN_PULL_OE <= 8'h00;
        end else begin
            TABLE_PAIR_A_HYST_HALF <= HYST_UNIT_A_SEL ? {1'b0, table_pair_a_hysteresis}
                                                      : {table_pair_a_hysteresis, 1'b0};
            TABLE_PAIR_B_HYST_HALF <= HYST_UNIT_B_SEL ? {1'b0, table_pair_b_hysteresis}
                                                      : {table_pair_b_hysteresis, 1'b0};
            TABLE_PAIR_A_FLOOR_STEP <= (table_pair_a_floor_duty > `FZF_FLOOR_TOP_STEP)
                                       ? `FZF_FLOOR_TOP_STEP : table_pair_a_floor_duty;
            TABLE_PAIR_B_FLOOR_STEP <= (table_pair_b_floor_duty > `FZF_FLOOR_TOP_STEP)
                                       ? `FZF_FLOOR_TOP_STEP : table_pair_b_floor_duty;
            // open drain: the level stays low, only the enable follows the register
            PIN_PULL_OUT <= 8'h00; // drives low only
            PIN_PULL_OE <= pulldown_reg;
        end
    end

endmodule

/* tb/fzf_regs_asserts.sv */
// assertion checker for the fan zone filter register bank
`timescale 1ns/10ps
module fzf_regs_asserts (
    // clock, reset and register port
    input wire CORE_CLK,
    input wire RST,
    input wire [7:0] REG_ADDR,
    input wire REG_WR,
    input wire [7:0] REG_WDATA,
    input wire REG_RD,
    input wire [7:0] REG_RDATA,
    // zone and pin side
    input wire [31:0] RAW_TEMP,
    input wire CONV_DONE,
    input wire HYST_UNIT_A_SEL,
    input wire [47:0] FILT_TEMP,
    input wire [31:0] CTRL_TEMP,
    input wire [4:0] TABLE_PAIR_A_HYST_HALF,
    input wire [3:0] TABLE_PAIR_A_FLOOR_STEP,
    input wire [7:0] PIN_PULL_OUT,
    input wire [7:0] PIN_PULL_OE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    reg [7:0] spk_reg;
    wire wr_c3 = REG_WR && REG_ADDR == 8'hC3;
    wire [3:0] wd_floor = REG_WDATA[7:4];
    wire [3:0] wd_hyst = REG_WDATA[3:0];
    wire [15:0] raw_a = RAW_TEMP[15:0];
    wire [15:0] raw_b = RAW_TEMP[31:16];
    wire [11:0] filt_z0 = FILT_TEMP[11:0];
    wire [11:0] tgt_z0 = {RAW_TEMP[7:0], 4'h0};
    wire [7:0] filt_int_z0 = FILT_TEMP[11:4];
    wire [7:0] filt_int_z3 = FILT_TEMP[47:40];
    // mirror of the smoothing control, needed to know the source in use
    always @(posedge CORE_CLK) begin
        if (RST)
            spk_reg <= 8'h00;
        else if (REG_WR && REG_ADDR == 8'hC2)
            spk_reg <= REG_WDATA;
    end
    AST_PULL_WRITE: assert property (REG_WR && REG_ADDR == 8'hC5 |->
        ##2 PIN_PULL_OE == $past(REG_WDATA, 2)) else $error("pin pull-down not applied");
    AST_PULL_LEVEL: assert property (PIN_PULL_OUT == 8'h00)
        else $error("pin driven high");
    AST_READ_PULL: assert property (REG_RD && REG_ADDR == 8'hC5 |=>
        REG_RDATA == PIN_PULL_OE) else $error("pull-down readback differs");
    AST_READ_HOLE: assert property (REG_RD && (REG_ADDR < 8'hC2 || REG_ADDR > 8'hC5) |=>
        REG_RDATA == 8'h00) else $error("unmapped read not zero");
    AST_RDATA_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("rdata moved");
    AST_FLOOR_CLAMP: assert property (wr_c3 |-> ##2 TABLE_PAIR_A_FLOOR_STEP ==
        ($past(wd_floor, 2) > 4'hC ? 4'hC : $past(wd_floor, 2)))
        else $error("floor step wrong");
    AST_HYST_UNIT: assert property (wr_c3 |-> ##2 TABLE_PAIR_A_HYST_HALF ==
        ($past(HYST_UNIT_A_SEL) ? {1'b0, $past(wd_hyst, 2)} :
        {$past(wd_hyst, 2), 1'b0})) else $error("hysteresis scaling wrong");
    AST_RAW_A: assert property (!spk_reg[3] |=> CTRL_TEMP[15:0] == $past(raw_a))
        else $error("zone a raw source wrong");
    AST_RAW_B: assert property (!spk_reg[7] |=> CTRL_TEMP[31:16] == $past(raw_b))
        else $error("zone b raw source wrong");
    AST_USE_A: assert property (spk_reg[3] |=> CTRL_TEMP[7:0] == $past(filt_int_z0))
        else $error("zone a filtered source wrong");
    AST_USE_B: assert property (spk_reg[7] |=> CTRL_TEMP[31:24] == $past(filt_int_z3))
        else $error("zone b filtered source wrong");
    AST_FILT_STEP: assert property (CONV_DONE && tgt_z0 > filt_z0 |=>
        filt_z0 > $past(filt_z0)) else $error("filter did not step");
    AST_FILT_HOLD: assert property (!CONV_DONE |=> $stable(FILT_TEMP))
        else $error("filter moved");
    cover property (wr_c3 && REG_WDATA[7:4] > 4'hC);
    cover property (CONV_DONE && spk_reg[3]);
    cover property (REG_RD && REG_ADDR == 8'hC5);
endmodule

/* tb/fzf_regs_tb.sv */
// self-checking bench for the fan zone filter register bank
`timescale 1ns/10ps
module fzf_regs_tb;
    reg CORE_CLK = 1'b0;
    reg RST = 1'b1;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg conv = 1'b0;
    reg sel_a = 1'b0;
    reg sel_b = 1'b0;
    reg [31:0] raw = 32'h0000_0000;
    wire [7:0] rdata, pull_out, pull_oe;
    wire [47:0] filt;
    wire [31:0] ctrl;
    wire [4:0] hyst_a, hyst_b;
    wire [3:0] floor_a, floor_b;
    logic [7:0] mode [4] = '{8'hFF, 8'h7F, 8'hF7, 8'h07};
    logic [31:0] want [4] = '{32'h2B2A_2928, 32'h1312_2928, 32'h2B2A_1110, 32'h1312_1110};
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int i;
    reg [3:0] ha, hb;
    fzf_regs dut (.CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(addr), .REG_WR(wr),
        .REG_WDATA(wdata), .REG_RD(rd), .REG_RDATA(rdata), .RAW_TEMP(raw), .CONV_DONE(conv),
        .HYST_UNIT_A_SEL(sel_a), .HYST_UNIT_B_SEL(sel_b), .FILT_TEMP(filt), .CTRL_TEMP(ctrl),
        .TABLE_PAIR_A_HYST_HALF(hyst_a), .TABLE_PAIR_B_HYST_HALF(hyst_b),
        .TABLE_PAIR_A_FLOOR_STEP(floor_a), .TABLE_PAIR_B_FLOOR_STEP(floor_b),
        .PIN_PULL_OUT(pull_out), .PIN_PULL_OE(pull_oe));
    // clock and run-length guard
    always #25 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle strobes, launched and released at falling edges
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge CORE_CLK);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge CORE_CLK);
        wr = 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge CORE_CLK);
        addr = a;
        rd = 1'b1;
        @(negedge CORE_CLK);
        rd = 1'b0;
        chk("read data", rdata, exp);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        RST = 1'b0;
        for (i = 0; i < 6; i++) rreg(8'hC1 + i[7:0], 8'h00);
        $display("test reset values done");
        for (i = 0; i < 4; i++) wreg(8'hC2 + i[7:0], 8'hA5 ^ i[7:0]);
        wreg(8'hC6, 8'hFF);
        for (i = 0; i < 5; i++) rreg(8'hC2 + i[7:0], i < 4 ? 8'hA5 ^ i[7:0] : 8'h00);
        chk("pull enables", pull_oe, 8'hA6);
        chk("pull level", pull_out, 8'h00);
        wreg(8'hC5, 8'h00);
        @(negedge CORE_CLK);
        chk("pull released", pull_oe, 8'h00);
        $display("test read write done");
        for (i = 0; i < 16; i++) begin
            sel_a = i[0];
            sel_b = ~i[0];
            ha = (i == 0) ? 4'h8 : i[3:0];
            hb = 4'h0 - ha;
            wreg(8'hC3, {i[3:0], ha});
            wreg(8'hC4, {i[3:0], hb});
            @(negedge CORE_CLK);
            chk("floor a", floor_a, i > 12 ? 4'hC : i[3:0]);
            chk("floor b", floor_b, i > 12 ? 4'hC : i[3:0]);
            chk("hyst a", hyst_a, sel_a ? {1'b0, ha} : {ha, 1'b0});
            chk("hyst b", hyst_b, sel_b ? {1'b0, hb} : {hb, 1'b0});
        end
        $display("test table pairs done");
        raw = 32'h2B2A_2928;
        wreg(8'hFF, 8'h00);
        wreg(8'hC2, 8'hFF);
        repeat (300) @(negedge CORE_CLK) conv = ~conv;
        raw = 32'h1312_1110;
        repeat (2) @(negedge CORE_CLK);
        for (i = 0; i < 4; i++) begin
            wreg(8'hC2, mode[i]);
            @(negedge CORE_CLK);
            chk("control temp", ctrl, want[i]);
        end
        chk("settled filter", filt, 48'h2B02_A029_0280);
        @(negedge CORE_CLK) conv = 1'b1;
        @(negedge CORE_CLK) conv = 1'b0;
        chk("one step", filt, 48'h2AA2_9A23_0220);
        $display("test filter done");
        final_report();
    end
endmodule
bind fzf_regs fzf_regs_asserts u_chk (.CORE_CLK, .RST, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD,
    .REG_RDATA, .RAW_TEMP, .CONV_DONE, .HYST_UNIT_A_SEL, .FILT_TEMP, .CTRL_TEMP,
    .TABLE_PAIR_A_HYST_HALF, .TABLE_PAIR_A_FLOOR_STEP, .PIN_PULL_OUT, .PIN_PULL_OE);
